// ### design/sesc_consts.vh
`ifndef SESC_CONSTS_VH
`define SESC_CONSTS_VH

// Word addresses
`define SESC_ADDR_W          6
`define SESC_DATA_W          16
`define SESC_LAST_USER_ADDR  6'h3c
`define SESC_ADDR_INIT_SW    6'h3d
`define SESC_ADDR_CONFIG     6'h3e
`define SESC_ADDR_READBACK   6'h3f

// Instruction opcodes after the start bit
`define SESC_OP_EXT          2'h0
`define SESC_OP_WRITE        2'h1
`define SESC_OP_READ         2'h2
`define SESC_OP_ERASE        2'h3
`define SESC_EXT_ENABLE      2'h3
`define SESC_EXT_DISABLE     2'h0
`define SESC_CMD_BITS        8
`define SESC_ERASED_WORD     16'hffff

// Readback word: terminal bits sit at 15..8
`define SESC_RB_LSB          8
`define SESC_RB_ZERO_LOW     8'h00

// Write queue
`define SESC_FIFO_DEPTH      32
`define SESC_FIFO_AW         5

// Timing
`define SESC_CLK_PERIOD_NS   10
`define SESC_PROG_TIME_NS    10000000
`define SESC_PROG_CNT_W      24

`endif

// ### design/sesc_switch_ctrl.v
`timescale 1ns/1ps
`include "sesc_consts.vh"


module sesc_fifo
#(
    parameter WIDTH = 22,
    parameter DEPTH = `SESC_FIFO_DEPTH,
    parameter AW    = `SESC_FIFO_AW
)
(
    input  wire             clock,
    input  wire             rst_n,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_r;
    reg [AW-1:0]    rdPtr_r;
    reg [AW:0]      count_r;
    wire            doPush;
    wire            doPop;

    assign inReady  = (count_r != DEPTH[AW:0]);
    assign outValid = (count_r != {(AW+1){1'b0}});
    assign outData  = store[rdPtr_r];
    assign doPush   = inValid & inReady;
    assign doPop    = outValid & outReady;

    always @(posedge clock)
    begin
        if (doPush)
            store[wrPtr_r] <= inData;
    end

    // Pointers wrap naturally only when DEPTH is a power of two
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (doPush)
                wrPtr_r <= wrPtr_r + 1'b1;
            if (doPop)
                rdPtr_r <= rdPtr_r + 1'b1;
            if (doPush && !doPop)
                count_r <= count_r + 1'b1;
            else if (doPop && !doPush)
                count_r <= count_r - 1'b1;
        end
    end
endmodule // sesc_fifo

module sesc_switch_ctrl
#(
    parameter PROG_CYCLES = `SESC_PROG_TIME_NS / `SESC_CLK_PERIOD_NS,
    parameter PAIRS       = 4
)
(
    input  wire             clock,
    input  wire             rst_n,
    input  wire             chipSelect,
    input  wire             serial_clock_pin,
    input  wire             serialDataIn,
    output reg              serialDataOut,
    output reg              serialDataOutEn,
    input  wire [PAIRS-1:0] termAIn,
    input  wire [PAIRS-1:0] termBIn,
    output reg  [PAIRS-1:0] termAOut,
    output reg  [PAIRS-1:0] termAOe,
    output reg  [PAIRS-1:0] termBOut,
    output reg  [PAIRS-1:0] termBOe,
    output reg  [PAIRS-1:0] analogClosed
);
    localparam ST_IDLE  = 3'd0;
    localparam ST_CMD   = 3'd1;
    localparam ST_READ  = 3'd2;
    localparam ST_DIN   = 3'd3;
    localparam ST_WEND  = 3'd4;
    localparam ST_WAIT  = 3'd5;
    localparam QW       = `SESC_ADDR_W + `SESC_DATA_W;

    reg  [`SESC_DATA_W-1:0] nvArray [0:`SESC_ADDR_READBACK];
    reg  [`SESC_DATA_W-1:0] switch_config_word;
    reg  [`SESC_DATA_W-1:0] switch_readback_word;

    reg                     csS1_r, csS2_r;
    reg                     skS1_r, skS2_r, skPrev_r;
    reg                     diS1_r, diS2_r;
    reg  [PAIRS-1:0]        taS1_r, taS2_r, tbS1_r, tbS2_r;

    reg  [2:0]              state_r;
    reg  [4:0]              bitCnt_r;
    reg  [`SESC_CMD_BITS-2:0] cmdSr_r;
    reg  [`SESC_ADDR_W-1:0] addr_r;
    reg  [`SESC_DATA_W-1:0] shift_r;
    reg                     writeEn_r;
    reg                     cfgLoaded_r;
    reg                     progActive_r;
    reg  [`SESC_PROG_CNT_W-1:0] progCnt_r;
    reg  [QW-1:0]           progWord_r;
    reg                     pushValid;

    wire                    skRise;
    wire [1:0]              opNow;
    wire [`SESC_ADDR_W-1:0] addrNow;
    wire [`SESC_ADDR_W-1:0] addrNext;
    wire [PAIRS*2-1:0]      rbNow;
    wire                    qReady;
    wire                    qValid;
    wire [QW-1:0]           qData;
    wire                    qPop;
    wire                    busy;

    assign skRise   = skS2_r & ~skPrev_r;
    assign opNow    = cmdSr_r[`SESC_CMD_BITS-2:`SESC_CMD_BITS-3];
    assign addrNow  = {cmdSr_r[`SESC_ADDR_W-2:0], diS2_r};
    assign addrNext = addr_r + 1'b1;
    assign qPop     = qValid & ~progActive_r;
    assign busy     = progActive_r | qValid;

    // Live terminal levels, zeroed for a closed analog switch
    genvar p;
    generate
        for (p = 0; p < PAIRS; p = p + 1)
        begin : gPair
            wire [3:0] m = switch_config_word[4*p+3:4*p];
            wire       closed = (m[3:1] == 3'b111);
            assign rbNow[2*p]   = closed ? 1'b0 : taS2_r[p];
            assign rbNow[2*p+1] = closed ? 1'b0 : tbS2_r[p];

            always @(posedge clock)
            begin
                if (!rst_n || !cfgLoaded_r)
                begin
                    termAOut[p]     <= 1'b0;
                    termAOe[p]      <= 1'b0;
                    termBOut[p]     <= 1'b0;
                    termBOe[p]      <= 1'b0;
                    analogClosed[p] <= 1'b0;
                end
                else
                begin
                    termAOut[p]     <= 1'b0;
                    termAOe[p]      <= 1'b0;
                    termBOut[p]     <= 1'b0;
                    termBOe[p]      <= 1'b0;
                    analogClosed[p] <= 1'b0;
                    case (m)
                        4'd0, 4'd1, 4'd2, 4'd3:
                        begin
                            termAOut[p] <= m[1];
                            termAOe[p]  <= 1'b1;
                            termBOut[p] <= m[0];
                            termBOe[p]  <= 1'b1;
                        end
                        4'd4, 4'd7:
                        begin
                            termAOut[p] <= m[1];
                            termAOe[p]  <= 1'b1;
                        end
                        4'd8, 4'd11:
                        begin
                            termBOut[p] <= m[1];
                            termBOe[p]  <= 1'b1;
                        end
                        4'd5:
                        begin
                            termAOut[p] <= tbS2_r[p];
                            termAOe[p]  <= 1'b1;
                        end
                        4'd6:
                        begin
                            termAOut[p] <= ~tbS2_r[p];
                            termAOe[p]  <= 1'b1;
                        end
                        4'd9:
                        begin
                            termBOut[p] <= taS2_r[p];
                            termBOe[p]  <= 1'b1;
                        end
                        4'd10:
                        begin
                            termBOut[p] <= ~taS2_r[p];
                            termBOe[p]  <= 1'b1;
                        end
                        default:
                            analogClosed[p] <= m[1];
                    endcase
                end
            end
        end
    endgenerate

    // Word delivered by a read at address a
    function [`SESC_DATA_W-1:0] wordAt;
        input [`SESC_ADDR_W-1:0] a;
        begin
            if (a == `SESC_ADDR_CONFIG)
                wordAt = switch_config_word;
            else if (a == `SESC_ADDR_READBACK)
                wordAt = {rbNow, `SESC_RB_ZERO_LOW};
            else
                wordAt = nvArray[a];
        end
    endfunction

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            csS1_r   <= 1'b0;
            csS2_r   <= 1'b0;
            skS1_r   <= 1'b0;
            skS2_r   <= 1'b0;
            skPrev_r <= 1'b0;
            diS1_r   <= 1'b0;
            diS2_r   <= 1'b0;
            taS1_r   <= {PAIRS{1'b0}};
            taS2_r   <= {PAIRS{1'b0}};
            tbS1_r   <= {PAIRS{1'b0}};
            tbS2_r   <= {PAIRS{1'b0}};
        end
        else
        begin
            csS1_r   <= chipSelect;
            csS2_r   <= csS1_r;
            skS1_r   <= serial_clock_pin;
            skS2_r   <= skS1_r;
            skPrev_r <= skS2_r;
            diS1_r   <= serialDataIn;
            diS2_r   <= diS1_r;
            taS1_r   <= termAIn;
            taS2_r   <= taS1_r;
            tbS1_r   <= termBIn;
            tbS2_r   <= tbS1_r;
        end
    end

    // Programming engine drains the write queue one word at a time
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            progActive_r <= 1'b0;
            progCnt_r    <= {`SESC_PROG_CNT_W{1'b0}};
            progWord_r   <= {QW{1'b0}};
        end
        else if (qPop)
        begin
            progActive_r <= 1'b1;
            progCnt_r    <= PROG_CYCLES[`SESC_PROG_CNT_W-1:0];
            progWord_r   <= qData;
        end
        else if (progActive_r)
        begin
            if (progCnt_r <= 1)
                progActive_r <= 1'b0;
            progCnt_r <= progCnt_r - 1'b1;
        end
    end

    always @(posedge clock)
    begin
        if (progActive_r && progCnt_r <= 1)
            nvArray[progWord_r[QW-1:`SESC_DATA_W]] <=
                progWord_r[`SESC_DATA_W-1:0];
    end

    // Serial command engine
    always @(posedge clock)
    begin
        pushValid <= 1'b0;
        if (!rst_n)
        begin
            state_r              <= ST_IDLE;
            bitCnt_r             <= 5'd0;
            cmdSr_r              <= {(`SESC_CMD_BITS-1){1'b0}};
            addr_r               <= {`SESC_ADDR_W{1'b0}};
            shift_r              <= {`SESC_DATA_W{1'b0}};
            writeEn_r            <= 1'b0;
            cfgLoaded_r          <= 1'b0;
            switch_config_word   <= {`SESC_DATA_W{1'b0}};
            switch_readback_word <= {`SESC_DATA_W{1'b0}};
            serialDataOut        <= 1'b0;
            serialDataOutEn      <= 1'b0;
        end
        else if (!cfgLoaded_r)
        begin
            // One cycle after reset, far inside the 1 ms limit
            switch_config_word <= nvArray[`SESC_ADDR_INIT_SW];
            cfgLoaded_r        <= 1'b1;
        end
        else if (!csS2_r)
        begin
            // Dropping select aborts any read cleanly
            state_r         <= ST_IDLE;
            serialDataOutEn <= 1'b0;
            serialDataOut   <= 1'b0;
            if (state_r == ST_WEND && writeEn_r)
            begin
                if (addr_r == `SESC_ADDR_CONFIG)
                    switch_config_word <= shift_r;
                else if (addr_r != `SESC_ADDR_READBACK && qReady)
                    pushValid <= 1'b1;
            end
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    serialDataOutEn <= 1'b1;
                    serialDataOut   <= ~busy;
                    if (skRise && diS2_r)
                    begin
                        state_r  <= ST_CMD;
                        bitCnt_r <= 5'd0;
                    end
                end
                ST_CMD:
                if (skRise)
                begin
                    cmdSr_r  <= {cmdSr_r[`SESC_CMD_BITS-3:0], diS2_r};
                    bitCnt_r <= bitCnt_r + 1'b1;
                    if (bitCnt_r == `SESC_CMD_BITS - 1)
                    begin
                        addr_r   <= addrNow;
                        bitCnt_r <= 5'd0;
                        state_r  <= ST_WAIT;
                        case (opNow)
                            `SESC_OP_READ:
                            begin
                                state_r       <= ST_READ;
                                shift_r       <= wordAt(addrNow);
                                serialDataOut <= 1'b0;
                                if (addrNow == `SESC_ADDR_READBACK)
                                    switch_readback_word <=
                                        wordAt(addrNow);
                            end
                            `SESC_OP_WRITE:
                                state_r <= ST_DIN;
                            `SESC_OP_ERASE:
                            begin
                                state_r <= ST_WEND;
                                shift_r <= `SESC_ERASED_WORD;
                            end
                            default:
                            begin
                                if (addrNow[5:4] == `SESC_EXT_ENABLE)
                                    writeEn_r <= 1'b1;
                                else if (addrNow[5:4] == `SESC_EXT_DISABLE)
                                    writeEn_r <= 1'b0;
                            end
                        endcase
                    end
                end
                ST_READ:
                begin
                    serialDataOutEn <= 1'b1;
                    if (skRise)
                    begin
                        serialDataOut <= shift_r[`SESC_DATA_W-1];
                        bitCnt_r      <= bitCnt_r + 1'b1;
                        if (bitCnt_r == `SESC_DATA_W - 1)
                        begin
                            // Next word follows with no gap bit
                            bitCnt_r <= 5'd0;
                            addr_r   <= addrNext;
                            shift_r  <= wordAt(addrNext);
                            if (addrNext == `SESC_ADDR_READBACK)
                                switch_readback_word <=
                                    wordAt(addrNext);
                        end
                        else
                            shift_r <= {shift_r[`SESC_DATA_W-2:0], 1'b0};
                    end
                end
                ST_DIN:
                if (skRise)
                begin
                    shift_r  <= {shift_r[`SESC_DATA_W-2:0], diS2_r};
                    bitCnt_r <= bitCnt_r + 1'b1;
                    if (bitCnt_r == `SESC_DATA_W - 1)
                        state_r <= ST_WEND;
                end
                ST_WEND:
                if (skRise)
                    state_r <= ST_WAIT;
                ST_WAIT:
                    serialDataOutEn <= 1'b0;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    sesc_fifo
    #(
        .WIDTH (QW),
        .DEPTH (`SESC_FIFO_DEPTH),
        .AW    (`SESC_FIFO_AW)
    )
    uWriteQueue
    (
        .clock    (clock),
        .rst_n    (rst_n),
        .inValid  (pushValid),
        .inReady  (qReady),
        .inData   ({addr_r, shift_r}),
        .outValid (qValid),
        .outReady (qPop),
        .outData  (qData)
    );
endmodule // sesc_switch_ctrl

// ### tb/serial_eeprom_switch_ctrl_test.sv
`timescale 1ns/1ps
module serial_eeprom_switch_ctrl_test;
    reg         clock;
    reg         rst_n;
    reg  [3:0]  extA;
    reg  [3:0]  extB;
    wire        chipSelect;
    wire        serial_clock_pin;
    wire        serialDataIn;
    wire        serialDataOut;
    wire        serialDataOutEn;
    wire        doWire;
    wire [3:0]  termAIn;
    wire [3:0]  termBIn;
    wire [3:0]  termAOut;
    wire [3:0]  termAOe;
    wire [3:0]  termBOut;
    wire [3:0]  termBOe;
    wire [3:0]  analogClosed;
    integer     err_count;
    integer     samples_checked;
    integer     cycles;
    integer     k;
    reg  [15:0] d0;
    reg  [15:0] d60;
    reg  [15:0] d61;
    reg  [15:0] cfg;
    reg  [15:0] rb;
    reg  [80:0] q;
    reg  [63:0] wq;
    reg  [31:0] seed;

    assign doWire = serialDataOutEn ? serialDataOut : 1'bz;
    assign termAIn = (termAOe & termAOut) | (~termAOe & extA);
    assign termBIn = (termBOe & termBOut) | (~termBOe & extB);

    // Programming outlasts one write frame so queued words pile up
    sesc_switch_ctrl #(.PROG_CYCLES(600)) sesc_switch_ctrl_inst (
        .clock(clock), .rst_n(rst_n), .chipSelect(chipSelect),
        .serial_clock_pin(serial_clock_pin), .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn),
        .termAIn(termAIn), .termBIn(termBIn), .termAOut(termAOut),
        .termAOe(termAOe), .termBOut(termBOut), .termBOe(termBOe),
        .analogClosed(analogClosed));
    sesc_host_model host (
        .clock(clock), .chipSelect(chipSelect),
        .serial_clock_pin(serial_clock_pin), .serialDataIn(serialDataIn),
        .doWire(doWire));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles = cycles + 1;
        if (cycles == 40000)
        begin
            err_count = err_count + 1;
            stop_test;
        end
    end

    // {A enable, A level, B enable, B level, closed}; levels 0 when floating
    function [4:0] mexp(input [3:0] m, input a, input b);
    begin
        case (m)
            4'h0, 4'h1, 4'h2, 4'h3: mexp = {1'b1, m[1], 1'b1, m[0], 1'b0};
            4'h4: mexp = 5'h10;
            4'h7: mexp = 5'h18;
            4'h8: mexp = 5'h04;
            4'hb: mexp = 5'h06;
            4'h5: mexp = {1'b1, b, 3'h0};
            4'h6: mexp = {1'b1, ~b, 3'h0};
            4'h9: mexp = {2'h0, 1'b1, a, 1'b0};
            4'ha: mexp = {2'h0, 1'b1, ~a, 1'b0};
            default: mexp = {4'h0, m[1]};
        endcase
    end
    endfunction
    function [15:0] rbexp(input [15:0] c);
        integer i;
        reg [4:0] e;
    begin
        rbexp = 16'h0000;
        for (i = 0; i < 4; i = i + 1)
        begin
            e = mexp(c[4*i+:4], extA[i], extB[i]);
            rbexp[8+2*i] = !e[0] && (e[4] ? e[3] : extA[i]);
            rbexp[9+2*i] = !e[0] && (e[2] ? e[1] : extB[i]);
        end
    end
    endfunction

    task check(input logic [31:0] got, input logic [31:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task stop_test;
    begin
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task do_reset;
    begin
        @(negedge clock);
        rst_n = 1'b0;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
    end
    endtask
    task put(input [5:0] a, input [15:0] d, input bx);
        reg busy;
        reg ok;
    begin
        host.write(a, d);
        host.poll(busy, ok);
        check(busy, bx);
        check(ok, 1'b1);
    end
    endtask
    task check_terms(input [15:0] c);
        integer i;
        reg [4:0] e;
        reg [3:0] g;
    begin
        repeat (10) @(negedge clock);
        for (i = 0; i < 4; i = i + 1)
        begin
            e = mexp(c[4*i+:4], extA[i], extB[i]);
            g = {termAOe[i], termAOut[i] & termAOe[i],
                 termBOe[i], termBOut[i] & termBOe[i]};
            check(analogClosed[i], e[0]);
            check(g, e[4:1]);
        end
    end
    endtask

    initial
    begin
        rst_n = 1'b0;
        extA = 4'h0;
        extB = 4'h0;
        err_count = 0;
        samples_checked = 0;
        cycles = 0;
        seed = $urandom(32'h3a72);
        do_reset;
        host.ewen;
        d0 = 16'($urandom);
        d60 = 16'($urandom);
        d61 = 16'($urandom);
        put(6'h00, d0, 1'b1);
        put(6'h3c, d60, 1'b1);
        put(6'h3d, d61, 1'b1);
        do_reset;
        check_terms(d61);
        $display("test power_up done");
        host.ewen;
        for (k = 0; k < 16; k = k + 1)
        begin
            cfg = {4'(k + 3), 4'(k + 2), 4'(k + 1), 4'(k)};
            @(negedge clock);
            {extB, extA} = 8'($urandom);
            put(6'h3e, cfg, 1'b0);
            check_terms(cfg);
            host.read(6'h3f, 2'($urandom), 16, q);
            check(q[16:0], {1'b0, rbexp(cfg)});
        end
        $display("test modes done");
        host.read(6'h3c, 2'h0, 80, q);
        rb = rbexp(cfg);
        check(q[80], 1'b0);
        check(q[79:48], {d60, d61});
        check(q[47:16], {cfg, rb});
        check(q[15:0], d0);
        host.write(6'h3f, ~rb);
        host.read(6'h3f, 2'h3, 8, q);
        check(q[8:0], {1'b0, rb[15:8]});
        host.read(6'h00, 2'h1, 16, q);
        check(q[15:0], d0);
        $display("test streaming done");
        // Frames arrive faster than programming, so words wait in the queue
        wq = {$urandom, $urandom};
        for (k = 0; k < 3; k = k + 1)
            host.write(6'(k + 1), wq[63-16*k-:16]);
        put(6'h04, wq[15:0], 1'b1);
        host.read(6'h01, 2'h2, 64, q);
        check(q[64], 1'b0);
        check(q[63:32], wq[63:32]);
        check(q[31:0], wq[31:0]);
        $display("test queue done");
        stop_test;
    end
endmodule // serial_eeprom_switch_ctrl_test

// ### tb/sesc_host_model.sv
`timescale 1ns/1ps
module sesc_host_model
(
    input  wire clock,
    output reg  chipSelect,
    output reg  serial_clock_pin,
    output reg  serialDataIn,
    input  wire doWire
);
    initial
    begin
        chipSelect = 1'b0;
        serial_clock_pin = 1'b0;
        serialDataIn = 1'b0;
    end
    // One 125 ns period; returns data out as it stood before this rise
    task clk_bit(input b, output r);
    begin
        serialDataIn = b;
        serial_clock_pin = 1'b0;
        #62.5;
        r = doWire;
        serial_clock_pin = 1'b1;
        #62.5;
    end
    endtask
    // Offset keeps pin edges away from the sampling clock edge
    task frame(input [1:0] op, input [5:0] adr, input [1:0] z);
        integer i;
        reg r;
    begin
        @(negedge clock);
        #1;
        chipSelect = 1'b1;
        for (i = 0; i < z; i = i + 1)
            clk_bit(1'b0, r);
        clk_bit(1'b1, r);
        for (i = 1; i >= 0; i = i - 1)
            clk_bit(op[i], r);
        for (i = 5; i >= 0; i = i - 1)
            clk_bit(adr[i], r);
    end
    endtask
    // Clock stops and data in toggles so a stale level is never reused
    task close;
    begin
        serial_clock_pin = 1'b0;
        chipSelect = 1'b0;
        serialDataIn = ~serialDataIn;
        #300;
    end
    endtask
    task ewen;
    begin
        frame(2'h0, 6'h30, 2'h0);
        close;
    end
    endtask
    task write(input [5:0] adr, input [15:0] d);
        integer i;
        reg r;
    begin
        frame(2'h1, adr, 2'h0);
        for (i = 15; i >= 0; i = i - 1)
            clk_bit(d[i], r);
        close;
    end
    endtask
    task read(input [5:0] adr, input [1:0] z, input integer n,
              output [80:0] q);
        integer i;
        reg r;
    begin
        q = 81'h0;
        frame(2'h2, adr, z);
        for (i = 0; i <= n; i = i + 1)
        begin
            clk_bit(i[0], r);
            q = {q[79:0], r};
        end
        close;
    end
    endtask
    task poll(output busy, output ok);
        integer k;
    begin
        @(negedge clock);
        #1;
        chipSelect = 1'b1;
        #100;
        busy = (doWire === 1'b0);
        ok = 1'b0;
        for (k = 0; k < 400 && !ok; k = k + 1)
        begin
            #50;
            ok = (doWire === 1'b1);
        end
        close;
    end
    endtask
endmodule // sesc_host_model

// ### tb/sesc_switch_ctrl_assertions.sv
`timescale 1ns/1ps
module sesc_switch_ctrl_assertions
#(
    parameter PAIRS = 4
)
(
    input wire             clock,
    input wire             rst_n,
    input wire             chipSelect,
    input wire             serial_clock_pin,
    input wire             serialDataIn,
    input wire             serialDataOut,
    input wire             serialDataOutEn,
    input wire [PAIRS-1:0] termAIn,
    input wire [PAIRS-1:0] termBIn,
    input wire [PAIRS-1:0] termAOut,
    input wire [PAIRS-1:0] termAOe,
    input wire [PAIRS-1:0] termBOut,
    input wire [PAIRS-1:0] termBOe,
    input wire [PAIRS-1:0] analogClosed
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_reset_quiet: assert property (
        $rose(rst_n) |-> !serialDataOutEn && !serialDataOut &&
        termAOe == '0 && termBOe == '0 && analogClosed == '0)
        else $error("outputs not idle at reset release");
    a_fell_quiet: assert property (
        $fell(chipSelect) |-> ##[1:6] !serialDataOutEn)
        else $error("data out still driven after deselect");
    a_deselect_float: assert property (
        (!chipSelect)[*5] |-> !serialDataOutEn)
        else $error("data out driven while deselected");
    a_idle_enable: assert property (
        $rose(chipSelect) ##1 (chipSelect && !serial_clock_pin)[*6]
        |-> serialDataOutEn)
        else $error("status not driven after select");
    a_status_monotone: assert property (
        (chipSelect && !serial_clock_pin)[*6] ##0
        (serialDataOutEn && serialDataOut) ##1
        (chipSelect && !serial_clock_pin) |-> serialDataOut)
        else $error("ready fell back without a clock edge");
    // After the load at reset, config may only move through a write or erase, which needs select
    a_config_hold: assert property (
        (!chipSelect)[*8] |-> termAOe === $past(termAOe) &&
        termBOe === $past(termBOe) &&
        analogClosed === $past(analogClosed))
        else $error("switch config changed while idle");
    a_fixed_drive: assert property (
        (!chipSelect)[*8] ##0 ((termAOe & termBOe) == {PAIRS{1'b1}})
        |=> $stable(termAOut) && $stable(termBOut))
        else $error("static terminal level moved");
    a_closed_legal: assert property (
        |analogClosed |-> (analogClosed & termAOe & termBOe) === '0)
        else $error("closed switch with both terminals driven");
endmodule // sesc_switch_ctrl_assertions

bind sesc_switch_ctrl sesc_switch_ctrl_assertions #(.PAIRS(PAIRS)) sesc_chk
(.*);
